// ==== design/gsc_top.sv ====
// gauge control: setpoint relay, degas timer, hour counters, addressing
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
module gsc_top #(
    parameter int TICKS_PER_SEC = gsc_pkg::CLK_HZ
) (
    input  wire logic                  MCLK_I,
    input  wire logic                  RST_I,
    input  wire gsc_pkg::gsc_press_type PRESS_I,
    input  wire logic                  TURN_ON_N_I,
    input  wire logic                  DEGAS_REQ_I,
    input  wire logic                  ERROR_I,
    input  wire logic                  ERR_CLR_I,
    input  wire logic                  HOST_MODE_I,
    input  wire logic                  HOST_ON_I,
    input  wire logic                  HOST_OFF_I,
    input  wire logic                  EMIT_4MA_SEL_I,
    input  wire logic [3:0]            ADDR_I,
    input  wire logic [7:0]            WADDR_I,
    input  wire logic [31:0]           WDATA_I,
    input  wire logic                  WR_I,
    input  wire logic                  RD_I,
    output logic [31:0]                RDATA_O,
    output logic                       RELAY_O,
    output logic                       FIL_ON_O,
    output logic                       FIL_SEL2_O,
    output logic                       DEGAS_O,
    output logic                       EMIT_4MA_O,
    output logic                       STATUS_ON_O,
    output logic [7:0]                 BUS_ADDR_O,
    output logic [2:0]                 BAUD_SEL_O
);
    localparam logic [7:0] A_DEGAS = 8'h00, A_SENS = 8'h04, A_FIL = 8'h08, A_LO = 8'h0C;
    localparam logic [7:0] A_HI = 8'h10, A_TEST = 8'h14, A_AUTO = 8'h18, A_AUTOP = 8'h1C;
    localparam logic [7:0] A_ADDR = 8'h20, A_BAUD = 8'h24, A_HRS1 = 8'h28, A_HRS2 = 8'h2C;
    localparam logic [7:0] A_DHRS1 = 8'h30, A_DHRS2 = 8'h34, A_OPT = 8'h38, A_STAT = 8'h3C;

    // pin inputs through two flops; all pins are ground-active, idle high
    logic [3:0] s1_r, s2_r;
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            s1_r <= 4'hF;
            s2_r <= 4'hF;
        end else begin
            s1_r <= {TURN_ON_N_I, DEGAS_REQ_I, ERROR_I, EMIT_4MA_SEL_I};
            s2_r <= s1_r;
        end
    end
    logic on_req, degas_pin, err_pin, emit_pin;
    // discrete ground held
    assign on_req    = ~s2_r[3];
    assign degas_pin = ~s2_r[2];
    assign err_pin   = ~s2_r[1];
    assign emit_pin  = ~s2_r[0];

    // one-second tick from divider
    logic [31:0] div_r, div_nxt;
    logic        sec_tick;
    assign sec_tick = (div_r == 32'(TICKS_PER_SEC - 1));
    always_comb begin
        div_nxt = sec_tick ? 32'h0000_0000 : div_r + 32'h0000_0001;
    end
    always_ff @(posedge MCLK_I) begin
        if (RST_I) div_r <= 32'h0000_0000;
        else div_r <= div_nxt;
    end

    // configuration registers
    logic [3:0]  degas_min_r, degas_min_nxt;
    logic [6:0]  sens_r, sens_nxt;
    logic        fil2_r, fil2_nxt, test_en_r, test_en_nxt, test_on_r, test_on_nxt;
    logic        auto_en_r, auto_en_nxt;
    gsc_pkg::gsc_press_type lo_r, lo_nxt, hi_r, hi_nxt, autop_r, autop_nxt, wp;
    logic [3:0]  addr_r, addr_nxt, ofs_r, ofs_nxt;
    logic [2:0]  baud_r, baud_nxt;
    assign wp = WDATA_I[15:0];
    always_comb begin
        degas_min_nxt = degas_min_r;
        sens_nxt = sens_r;
        fil2_nxt = fil2_r;
        lo_nxt = lo_r;
        hi_nxt = hi_r;
        test_en_nxt = test_en_r;
        test_on_nxt = test_on_r;
        auto_en_nxt = auto_en_r;
        autop_nxt = autop_r;
        addr_nxt = addr_r;
        ofs_nxt = ofs_r;
        baud_nxt = baud_r;
        if (WR_I) begin
            unique case (WADDR_I)
                A_DEGAS: if (WDATA_I[3:0] >= gsc_pkg::DEGAS_MIN_LO &&
                             WDATA_I[3:0] <= gsc_pkg::DEGAS_MIN_HI && WDATA_I[31:4] == 28'h0) begin
                    degas_min_nxt = WDATA_I[3:0];
                end
                A_SENS: if (WDATA_I[6:0] >= gsc_pkg::SENS_LO &&
                            WDATA_I[6:0] <= gsc_pkg::SENS_HI && WDATA_I[31:7] == 25'h0) begin
                    sens_nxt = WDATA_I[6:0];
                end
                A_FIL:  fil2_nxt = WDATA_I[0];
                A_LO:   lo_nxt = wp;
                A_HI:   hi_nxt = wp;
                A_TEST: begin
                    test_en_nxt = WDATA_I[0];
                    test_on_nxt = WDATA_I[1];
                end
                A_AUTO: auto_en_nxt = WDATA_I[0];
                A_AUTOP: if (!gsc_pkg::gsc_less(wp, gsc_pkg::P_1E6) &&
                             !gsc_pkg::gsc_less(gsc_pkg::P_1E4, wp)) begin
                    autop_nxt = wp;
                end
                A_ADDR: begin
                    addr_nxt = WDATA_I[3:0];
                    ofs_nxt  = WDATA_I[7:4];
                end
                A_BAUD: baud_nxt = WDATA_I[2:0];
                default: ;
            endcase
        end
    end
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            degas_min_r <= gsc_pkg::DEGAS_MIN_LO;
            sens_r <= gsc_pkg::SENS_RST;
            fil2_r <= 1'b0;
            lo_r <= gsc_pkg::P_1E6;
            hi_r <= gsc_pkg::P_5E6;
            test_en_r <= 1'b0;
            test_on_r <= 1'b0;
            auto_en_r <= 1'b0;
            autop_r <= gsc_pkg::P_1E6;
            addr_r <= gsc_pkg::ADDR_RST;
            ofs_r <= gsc_pkg::ADDR_OFS_RST;
            baud_r <= gsc_pkg::BAUD_19200;
        end else begin
            degas_min_r <= degas_min_nxt;
            sens_r <= sens_nxt;
            fil2_r <= fil2_nxt;
            lo_r <= lo_nxt;
            hi_r <= hi_nxt;
            test_en_r <= test_en_nxt;
            test_on_r <= test_on_nxt;
            auto_en_r <= auto_en_nxt;
            autop_r <= autop_nxt;
            addr_r <= addr_nxt;
            ofs_r <= ofs_nxt;
            baud_r <= baud_nxt;
        end
    end

    // filament sequencer
    gsc_pkg::gsc_state_type st_r, st_nxt;
    logic [3:0]  settle_r, settle_nxt;
    logic        want_on, want_off;
    logic        degas_r, degas_nxt;
    logic [9:0]  dsec_r, dsec_nxt;
    assign want_on  = HOST_MODE_I ? HOST_ON_I : on_req;
    assign want_off = HOST_MODE_I ? HOST_OFF_I : !on_req;
    always_comb begin
        st_nxt = st_r;
        settle_nxt = settle_r;
        degas_nxt = degas_r;
        dsec_nxt = dsec_r;
        unique case (st_r)
            gsc_pkg::GSC_OFF: if (want_on) begin
                st_nxt = gsc_pkg::GSC_SETTLE;
                settle_nxt = 4'h0;
            end
            gsc_pkg::GSC_SETTLE: begin
                if (want_off) st_nxt = gsc_pkg::GSC_OFF;
                else if (sec_tick) begin
                    settle_nxt = settle_r + 4'h1;
                    if (settle_r == 4'(gsc_pkg::EMIT_SETTLE_S - 1)) st_nxt = gsc_pkg::GSC_ON;
                end
            end
            gsc_pkg::GSC_ON: if (want_off) st_nxt = gsc_pkg::GSC_OFF;
            gsc_pkg::GSC_ERR: if (ERR_CLR_I) st_nxt = gsc_pkg::GSC_OFF;
        endcase
        // error set wins over a clear in the same cycle
        if (err_pin) st_nxt = gsc_pkg::GSC_ERR;
        if (st_nxt != gsc_pkg::GSC_ON) begin
            degas_nxt = 1'b0;
        end else if (!degas_r && (degas_pin || (WR_I && WADDR_I == A_STAT && WDATA_I[0]))) begin
            degas_nxt = 1'b1;
            dsec_nxt = 10'h000;
        end else if (degas_r && sec_tick) begin
            dsec_nxt = dsec_r + 10'h001;
            if (dsec_r == 10'(32'(degas_min_r) * gsc_pkg::SEC_PER_MIN - 1)) degas_nxt = 1'b0;
        end
    end
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            st_r <= gsc_pkg::GSC_OFF;
            settle_r <= 4'h0;
            degas_r <= 1'b0;
            dsec_r <= 10'h000;
        end else begin
            st_r <= st_nxt;
            settle_r <= settle_nxt;
            degas_r <= degas_nxt;
            dsec_r <= dsec_nxt;
        end
    end
    // relay hysteresis
    logic relay_r, relay_nxt, lo_below_hi, valid;
    assign lo_below_hi = gsc_pkg::gsc_less(lo_r, hi_r);
    assign valid = (st_r == gsc_pkg::GSC_ON);
    always_comb begin
        relay_nxt = relay_r;
        if (!valid) relay_nxt = 1'b0;
        else if (lo_below_hi) begin
            if (gsc_pkg::gsc_less(PRESS_I, lo_r)) relay_nxt = 1'b1;
            else if (gsc_pkg::gsc_less(hi_r, PRESS_I)) relay_nxt = 1'b0;
        end else begin
            if (gsc_pkg::gsc_less(lo_r, PRESS_I)) relay_nxt = 1'b1;
            else if (gsc_pkg::gsc_less(PRESS_I, hi_r)) relay_nxt = 1'b0;
        end
    end
    always_ff @(posedge MCLK_I) begin
        if (RST_I) relay_r <= 1'b0;
        else relay_r <= relay_nxt;
    end

    // hour logs in seconds, plus powered time
    logic [31:0] hrs_r [4], hrs_nxt [4];
    logic [31:0] opt_r, opt_nxt;
    always_comb begin
        for (int i = 0; i < 4; i++) hrs_nxt[i] = hrs_r[i];
        opt_nxt = opt_r;
        if (sec_tick) begin
            opt_nxt = opt_r + 32'h1;
            if (valid) hrs_nxt[fil2_r] = hrs_r[fil2_r] + 32'h1;
            if (degas_r) hrs_nxt[{1'b1, fil2_r}] = hrs_r[{1'b1, fil2_r}] + 32'h1;
        end
    end
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            for (int i = 0; i < 4; i++) hrs_r[i] <= 32'h0;
            opt_r <= 32'h0;
        end else begin
            for (int i = 0; i < 4; i++) hrs_r[i] <= hrs_nxt[i];
            opt_r <= opt_nxt;
        end
    end

    // emission range
    logic emit_r, emit_nxt;
    always_comb begin
        if (auto_en_r) emit_nxt = gsc_pkg::gsc_less(PRESS_I, autop_r);
        // manual range only through the synchronised pin
        else emit_nxt = emit_pin;
    end
    always_ff @(posedge MCLK_I) begin
        if (RST_I) emit_r <= 1'b0;
        else emit_r <= emit_nxt;
    end

    // read port
    logic [31:0] rd_r, rd_nxt;
    always_comb begin
        rd_nxt = 32'h0;
        if (RD_I) begin
            unique case (ADDR_I)
                4'h0: rd_nxt = {28'h0, degas_min_r};
                4'h1: rd_nxt = {25'h0, sens_r};
                4'h2: rd_nxt = {31'h0, fil2_r};
                4'h3: rd_nxt = {16'h0, lo_r};
                4'h4: rd_nxt = {16'h0, hi_r};
                4'h5: rd_nxt = {30'h0, test_on_r, test_en_r};
                4'h6: rd_nxt = {31'h0, auto_en_r};
                4'h7: rd_nxt = auto_en_r ? {16'h0, autop_r} : 32'h0;
                4'h8: rd_nxt = {24'h0, ofs_r, addr_r};
                4'h9: rd_nxt = {29'h0, baud_r};
                4'hA: rd_nxt = hrs_r[0] / gsc_pkg::SEC_PER_HOUR;
                4'hB: rd_nxt = hrs_r[1] / gsc_pkg::SEC_PER_HOUR;
                4'hC: rd_nxt = hrs_r[2] / gsc_pkg::SEC_PER_HOUR;
                4'hD: rd_nxt = hrs_r[3] / gsc_pkg::SEC_PER_HOUR;
                4'hE: rd_nxt = opt_r;
                4'hF: rd_nxt = {27'h0, emit_r, degas_r, relay_r, st_r};
            endcase
        end
    end
    always_ff @(posedge MCLK_I) begin
        if (RST_I) rd_r <= 32'h0;
        else rd_r <= rd_nxt;
    end

    assign RDATA_O     = rd_r;
    assign RELAY_O     = test_en_r ? test_on_r : relay_r;
    assign FIL_ON_O    = st_r == gsc_pkg::GSC_ON || st_r == gsc_pkg::GSC_SETTLE;
    assign FIL_SEL2_O  = fil2_r;
    assign DEGAS_O     = degas_r;
    assign EMIT_4MA_O  = emit_r;
    assign STATUS_ON_O = valid;
    assign BUS_ADDR_O  = {ofs_r, addr_r};
    assign BAUD_SEL_O  = baud_r;
endmodule
`default_nettype wire

// ==== include/gsc_pkg.sv ====
// constants, types and rule summary for the gauge setpoint control block
//
// Contract
// - degas runs programmed minutes, 2 to 10, reset value 2
// - sensitivity setting held, range 2 to 99, used for scaling; this block only stores it and reads it back
// - filament select chooses one of two, reset filament 1
// - low setpoint resets 1.00E-06, high setpoint resets 5.00E-06 Torr
// - low below high: energize below low, release above high
// - low above high: energize above low, release below high
// - manual relay test, off at reset, forces relay regardless of pressure
// - four hour counters, filament on and degas, starting at zero
// - auto emission switch enable off at reset, pressure reads disabled
// - switch pressure programmable from 1.00E-06 to 1.00E-04 Torr
// - auto enabled: 100 uA above switch pressure, 4 mA below
// - address low nibble from address setting, reset 1
// - address high nibble from offset setting, reset 0
// - serial rate programmable, reset 19200 baud 8N1
// - powered-on time accumulates whenever powered
// - up to 8 s after turn-on, unit status reports off
// - discrete mode: filament on only while turn-on input held
// - after gauge error filament off, turn-on refused until cleared
package gsc_pkg;
    // pressure code: 8-bit signed decade exponent, 8-bit mantissa x10 (1.0 to 9.9)
    // two digits only: a byte scaled x100 cannot hold a mantissa of 5.00
    typedef struct packed {
        logic [7:0] expo;
        logic [7:0] mant;
    } gsc_press_type;

    localparam int          CLK_HZ          = 250_000_000;
    localparam logic [15:0] P_1E6           = 16'hFA0A;
    localparam logic [15:0] P_5E6           = 16'hFA32;
    localparam logic [15:0] P_1E4           = 16'hFC0A;
    localparam logic [3:0]  DEGAS_MIN_LO    = 4'h2;
    localparam logic [3:0]  DEGAS_MIN_HI    = 4'hA;
    localparam logic [6:0]  SENS_LO         = 7'h02;
    localparam logic [6:0]  SENS_HI         = 7'h63;
    localparam logic [6:0]  SENS_RST        = 7'h0A;
    localparam logic [3:0]  ADDR_RST        = 4'h1;
    localparam logic [3:0]  ADDR_OFS_RST    = 4'h0;
    localparam logic [2:0]  BAUD_19200      = 3'h4;
    localparam int          EMIT_SETTLE_S   = 8;
    localparam int          SEC_PER_HOUR    = 3600;
    localparam int          SEC_PER_MIN     = 60;

    typedef enum logic [1:0] {
        GSC_OFF    = 2'b00,
        GSC_SETTLE = 2'b01,
        GSC_ON     = 2'b10,
        GSC_ERR    = 2'b11
    } gsc_state_type;

    // signed compare on the packed code, exponent first
    function automatic logic gsc_less(input gsc_press_type a, input gsc_press_type b);
        if (a.expo != b.expo) begin
            return $signed(a.expo) < $signed(b.expo);
        end
        return a.mant < b.mant;
    endfunction
endpackage

// ==== tb/gsc_contact_model.sv ====
// external relay contact that grounds the discrete turn-on input
`timescale 1ns/1ps
`default_nettype none
module gsc_contact_model (
    input  wire logic clk_i,
    input  wire logic close_i,
    output logic      turn_on_n_o
);
    initial turn_on_n_o = 1'b1;
    always @(posedge clk_i) begin
        turn_on_n_o <= !close_i;
    end
endmodule
`default_nettype wire

// ==== tb/gsc_top_asserts.sv ====
// concurrent checks on the gauge setpoint control ports
`timescale 1ns/1ps
`default_nettype none
module gsc_top_asserts #(
    parameter int TICKS_PER_SEC = gsc_pkg::CLK_HZ
) (
    input wire logic                   MCLK_I,
    input wire logic                   RST_I,
    input wire gsc_pkg::gsc_press_type PRESS_I,
    input wire logic                   TURN_ON_N_I,
    input wire logic                   ERROR_I,
    input wire logic                   HOST_MODE_I,
    input wire logic [7:0]             WADDR_I,
    input wire logic [31:0]            WDATA_I,
    input wire logic                   WR_I,
    input wire logic                   RD_I,
    input wire logic [31:0]            RDATA_O,
    input wire logic                   RELAY_O,
    input wire logic                   FIL_ON_O,
    input wire logic                   STATUS_ON_O
);
    logic signed [15:0] lo_r, lo_nxt, hi_r, hi_nxt;
    logic [1:0]         tst_r, tst_nxt;
    int unsigned        fil_r, fil_nxt;
    wire signed [15:0]  p_s = PRESS_I;
    wire                run = STATUS_ON_O && !tst_r[0];
    // shadow setpoints so relay checks need no internal probes
    always_comb begin
        lo_nxt = lo_r;
        hi_nxt = hi_r;
        tst_nxt = tst_r;
        fil_nxt = FIL_ON_O ? fil_r + 1 : 0;
        if (WR_I) begin
            case (WADDR_I)
                8'h0C: lo_nxt = WDATA_I[15:0];
                8'h10: hi_nxt = WDATA_I[15:0];
                8'h14: tst_nxt = WDATA_I[1:0];
                default: ;
            endcase
        end
    end
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            lo_r <= gsc_pkg::P_1E6;
            hi_r <= gsc_pkg::P_5E6;
            tst_r <= 2'h0;
            fil_r <= 0;
        end else begin
            lo_r <= lo_nxt;
            hi_r <= hi_nxt;
            tst_r <= tst_nxt;
            fil_r <= fil_nxt;
        end
    end
    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (RST_I);
    chk_relay_on_low: assert property ((run && lo_r < hi_r && p_s < lo_r)[*3] |-> RELAY_O)
        else $error("relay idle below low setpoint");
    chk_relay_on_rev: assert property ((run && lo_r > hi_r && p_s > lo_r)[*3] |-> RELAY_O)
        else $error("relay idle above inverted low setpoint");
    chk_relay_hold_band: assert property ((run && ((p_s >= lo_r && p_s <= hi_r)
        || (p_s >= hi_r && p_s <= lo_r)))[*3] |-> $stable(RELAY_O))
        else $error("relay changed between setpoints");
    chk_test_force: assert property ((STATUS_ON_O && tst_r[0])[*2] |-> RELAY_O == tst_r[1])
        else $error("relay does not follow manual test");
    chk_settle_time: assert property ($rose(STATUS_ON_O) |->
        fil_r >= 7 * TICKS_PER_SEC && fil_r <= 8 * TICKS_PER_SEC + 2)
        else $error("status on outside settle window");
    chk_rd_idle: assert property (!$past(RD_I) |-> RDATA_O == 32'h0)
        else $error("read data not zero outside read");
    chk_err_off: assert property ($fell(ERROR_I) |-> ##[1:5] !FIL_ON_O)
        else $error("filament kept on after error");
    chk_disc_hold: assert property ((!HOST_MODE_I && TURN_ON_N_I)[*5] |-> !FIL_ON_O)
        else $error("filament on without held input");
endmodule
bind gsc_top gsc_top_asserts #(.TICKS_PER_SEC(TICKS_PER_SEC)) chk_u (
    .MCLK_I, .RST_I, .PRESS_I, .TURN_ON_N_I, .ERROR_I, .HOST_MODE_I, .WADDR_I, .WDATA_I,
    .WR_I, .RD_I, .RDATA_O, .RELAY_O, .FIL_ON_O, .STATUS_ON_O
);
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench for the gauge setpoint control block
`timescale 1ns/1ps
`default_nettype none
module tb;
    typedef struct packed {
        logic [7:0]  a;
        logic [3:0]  i;
        logic [31:0] d;
        logic [31:0] e;
    } gsc_row_type;
    localparam int TPS = 2;
    localparam gsc_row_type ROWS [0:17] = '{
        '{8'h00, 4'h0, 32'h5, 32'h5}, '{8'h00, 4'h0, 32'h1, 32'h5}, '{8'h00, 4'h0, 32'hB, 32'h5},
        '{8'h00, 4'h0, 32'hA, 32'hA}, '{8'h40, 4'h0, 32'h7, 32'hA}, '{8'h04, 4'h1, 32'h1, 32'hA},
        '{8'h04, 4'h1, 32'h63, 32'h63}, '{8'h04, 4'h1, 32'h64, 32'h63},
        '{8'h04, 4'h1, 32'h2, 32'h2}, '{8'h08, 4'h2, 32'h1, 32'h1},
        '{8'h1C, 4'h7, 32'hFB0A, 32'h0}, '{8'h18, 4'h6, 32'h1, 32'h1},
        '{8'h1C, 4'h7, 32'hFB0A, 32'hFB0A}, '{8'h1C, 4'h7, 32'hF90A, 32'hFB0A},
        '{8'h1C, 4'h7, 32'hFC0B, 32'hFB0A}, '{8'h1C, 4'h7, 32'hFC0A, 32'hFC0A},
        '{8'h20, 4'h8, 32'hF5, 32'hF5}, '{8'h24, 4'h9, 32'h2, 32'h2}};
    localparam logic [31:0] RV [0:9] = '{32'h2, 32'hA, 32'h0, 32'hFA0A, 32'hFA32,
        32'h0, 32'h0, 32'h0, 32'h1, 32'h4};
    logic        MCLK_I = 1'b0, RST_I = 1'b1, ERROR_I = 1'b1, ERR_CLR_I = 1'b0, close = 1'b0;
    logic        HOST_MODE_I = 1'b0, HOST_ON_I = 1'b0, WR_I = 1'b0, RD_I = 1'b0;
    logic        HOST_OFF_I = 1'b0;
    logic [3:0]  ADDR_I = 4'h0;
    logic [7:0]  WADDR_I = 8'h00, BUS_ADDR_O;
    logic [31:0] WDATA_I = 32'h0, RDATA_O, v, v2;
    logic        RELAY_O, FIL_ON_O, FIL_SEL2_O, DEGAS_O, EMIT_4MA_O, STATUS_ON_O, TURN_ON_N_I;
    logic [2:0]  BAUD_SEL_O;
    int          n_fail = 0, check_count = 0, cyc = 0, n;
    gsc_pkg::gsc_press_type PRESS_I = 16'hFA14;
    gsc_contact_model contact_u (.clk_i(MCLK_I), .close_i(close), .turn_on_n_o(TURN_ON_N_I));
    gsc_top #(.TICKS_PER_SEC(TPS)) dut_u (
        .MCLK_I, .RST_I, .PRESS_I, .TURN_ON_N_I, .DEGAS_REQ_I(1'b1), .ERROR_I, .ERR_CLR_I,
        .HOST_MODE_I, .HOST_ON_I, .HOST_OFF_I, .EMIT_4MA_SEL_I(1'b1), .ADDR_I, .WADDR_I,
        .WDATA_I, .WR_I, .RD_I, .RDATA_O, .RELAY_O, .FIL_ON_O, .FIL_SEL2_O, .DEGAS_O,
        .EMIT_4MA_O, .STATUS_ON_O, .BUS_ADDR_O, .BAUD_SEL_O);
    always #2 MCLK_I = ~MCLK_I;
    always @(posedge MCLK_I) begin
        cyc <= cyc + 1;
        if (cyc == 12000) begin
            n_fail++;
            final_report();
        end
    end
    task automatic final_report();
        if (n_fail == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_b(input logic got, input logic exp);
        chk_w({31'h0, got}, {31'h0, exp});
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge MCLK_I);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        WADDR_I <= a;
        WDATA_I <= d;
        WR_I <= 1'b1;
        @(posedge MCLK_I);
        WR_I <= 1'b0;
        @(posedge MCLK_I);
    endtask
    task automatic rd(input logic [3:0] i, output logic [31:0] d);
        ADDR_I <= i;
        RD_I <= 1'b1;
        @(posedge MCLK_I);
        RD_I <= 1'b0;
        #1 d = RDATA_O;
        @(posedge MCLK_I);
    endtask
    // pressure step, then the relay once it has settled
    task automatic press(input logic [15:0] p, input logic r);
        PRESS_I <= p;
        tick(4);
        #1 chk_b(RELAY_O, r);
        @(posedge MCLK_I);
    endtask
    task automatic wait_on(output int k);
        k = 0;
        #1;
        while (STATUS_ON_O !== 1'b1 && k < 100) begin
            @(posedge MCLK_I);
            #1 k++;
        end
        @(posedge MCLK_I);
    endtask
    initial begin
        tick(4);
        RST_I <= 1'b0;
        @(posedge MCLK_I);
        foreach (ROWS[j]) begin
            wr(ROWS[j].a, ROWS[j].d);
            rd(ROWS[j].i, v);
            chk_w(v, ROWS[j].e);
        end
        chk_b(FIL_SEL2_O, 1'b1);
        chk_w({24'h0, BUS_ADDR_O}, 32'hF5);
        RST_I <= 1'b1;
        tick(4);
        RST_I <= 1'b0;
        @(posedge MCLK_I);
        for (int j = 0; j < 10; j++) begin
            rd(4'(j), v);
            chk_w(v, RV[j]);
        end
        chk_w({21'h0, BUS_ADDR_O, BAUD_SEL_O}, 32'hC);
        close <= 1'b1;
        tick(6);
        #1 chk_w({30'h0, FIL_ON_O, STATUS_ON_O}, 32'h2);
        wait_on(n);
        chk_b(n >= 6 && n <= 20, 1'b1);
        press(16'hF90A, 1'b1);
        press(16'hFA14, 1'b1);
        press(16'hFB0A, 1'b0);
        press(16'hFA14, 1'b0);
        wr(8'h0C, 32'hFB0A);
        wr(8'h10, 32'hFA0A);
        press(16'hFB14, 1'b1);
        press(16'hFA14, 1'b1);
        press(16'hF90A, 1'b0);
        wr(8'h14, 32'h3);
        press(16'hF90A, 1'b1);
        wr(8'h14, 32'h1);
        press(16'hFB14, 1'b0);
        wr(8'h14, 32'h0);
        wr(8'h18, 32'h1);
        wr(8'h1C, 32'hFB0A);
        tick(3);
        #1 chk_b(EMIT_4MA_O, 1'b0);
        @(posedge MCLK_I);
        PRESS_I <= 16'hFA14;
        tick(4);
        #1 chk_b(EMIT_4MA_O, 1'b1);
        @(posedge MCLK_I);
        wr(8'h3C, 32'h1);
        n = 0;
        // sample past the edge so the final clear is not raced
        while (DEGAS_O === 1'b1 && n < 400) begin
            @(posedge MCLK_I);
            #1 n++;
        end
        chk_b(n >= 236 && n <= 242, 1'b1);
        tick(7250);
        rd(4'hA, v);
        chk_w(v, 32'h1);
        rd(4'hB, v);
        chk_w(v, 32'h0);
        close <= 1'b0;
        tick(6);
        #1 chk_b(FIL_ON_O, 1'b0);
        @(posedge MCLK_I);
        rd(4'hE, v);
        tick(20);
        rd(4'hE, v2);
        chk_b(v2 - v >= 32'hA && v2 - v <= 32'hC, 1'b1);
        HOST_MODE_I <= 1'b1;
        HOST_ON_I <= 1'b1;
        @(posedge MCLK_I);
        HOST_ON_I <= 1'b0;
        wait_on(n);
        chk_b(n >= 6 && n <= 20, 1'b1);
        ERROR_I <= 1'b0;
        tick(6);
        ERROR_I <= 1'b1;
        HOST_ON_I <= 1'b1;
        @(posedge MCLK_I);
        HOST_ON_I <= 1'b0;
        tick(4);
        #1 chk_b(FIL_ON_O, 1'b0);
        @(posedge MCLK_I);
        ERR_CLR_I <= 1'b1;
        @(posedge MCLK_I);
        ERR_CLR_I <= 1'b0;
        HOST_ON_I <= 1'b1;
        @(posedge MCLK_I);
        HOST_ON_I <= 1'b0;
        tick(4);
        #1 chk_b(FIL_ON_O, 1'b1);
        @(posedge MCLK_I);
        HOST_OFF_I <= 1'b1;
        @(posedge MCLK_I);
        HOST_OFF_I <= 1'b0;
        tick(2);
        #1 chk_b(FIL_ON_O, 1'b0);
        final_report();
    end
endmodule
`default_nettype wire
